// File: logic/dbu_cfg.svh
/*
  Constants of the debug breakpoint unit: register addresses, field
  positions, reset values and cycle counts.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef DBU_CFG_SVH
`define DBU_CFG_SVH

// Register addresses in the special function register space
`define DBU_OFS_MON_CTRL_TWO  8'he9
`define DBU_OFS_MON_CTRL      8'hf1
`define DBU_OFS_MON_STATUS    8'hf2
`define DBU_OFS_BRK_CTRL      8'hf3
`define DBU_OFS_INT_CTRL      8'hf4
`define DBU_OFS_MON_DATA      8'hf5
`define DBU_OFS_BP_SELECT     8'hf6
`define DBU_OFS_BP_WINDOW     8'hf7

// Reset value of every register byte
`define DBU_RST_BYTE          8'h00

// Breakpoint select register fields
`define DBU_SEL_GUARD_BIT     4
`define DBU_SEL_VALID_BIT     3
`define DBU_SEL_FIELD_MSB     3

// Break control register fields
`define DBU_BC_PAIR_RANGE     0
`define DBU_BC_CMP2_RANGE     1
`define DBU_BC_CMP3_RANGE     2
`define DBU_BC_PIN_BREAK_EN   3
`define DBU_BC_PIN_ACT_EN     4
`define DBU_BC_PIN_ONLY       5

// Monitor control: comparator enables in the low nibble
`define DBU_MC_EN_MSB         3

// Monitor status fields
`define DBU_ST_HW             0
`define DBU_ST_SW             1
`define DBU_ST_EXT            2
`define DBU_ST_MON            3
`define DBU_ST_HELD           4
`define DBU_ST_DATA           5

// Stall and pin low time in system clock cycles, then a quiet guard
`define DBU_STALL_CYC         4
`define DBU_PIN_GUARD_CYC     3

`endif

// File: logic/dbu_pkg.sv
/*
  Types shared by the debug breakpoint unit.
  Assumes nothing of its surroundings.
*/
package dbu_pkg;

  // Top-level action state
  typedef enum logic [1:0] {
    DBU_ST_RUN,
    DBU_ST_STALL,
    DBU_ST_MON
  } dbu_state_e;

  typedef logic [7:0]  dbu_byte_t;
  typedef logic [15:0] dbu_addr_t;

endpackage

// File: logic/dbu_top.sv
/*
  Debug breakpoint unit: four address comparators, trap and external
  break recognition, monitor start and debug control pin action.
  Assumes a same-clock core interface (fetch, internal data memory
  strobes, NMI level, monitor exit) and a simple single-cycle register
  port; test port clock/request and the debug pin are asynchronous.
*/
`timescale 1ns/10ps
`include "dbu_cfg.svh"

module dbu_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // Core side
  input  wire logic        i_fetch_first,
  input  wire logic [15:0] i_fetch_addr,
  input  wire logic        i_fetch_trap,
  input  wire logic        i_trap_enable,
  input  wire logic        i_internal_data_memory_is_ram,
  input  wire logic        i_internal_data_memory_rd,
  input  wire logic [7:0]  i_internal_data_memory_rd_addr,
  input  wire logic        i_internal_data_memory_wr,
  input  wire logic [7:0]  i_internal_data_memory_wr_addr,
  input  wire logic        i_nmi_active,
  input  wire logic        i_monitor_exit,
  input  wire logic        i_step_req,
  // Serial test port, asynchronous
  input  wire logic        i_tport_clk,
  input  wire logic        i_tport_break,
  // Debug control pin, open drain
  input  wire logic        i_dbg_pin_in,
  output logic             o_dbg_pin_out,
  output logic             o_dbg_pin_oe_n,
  // Actions
  output logic             o_break_before,
  output logic             o_break_after,
  output logic             o_monitor_start,
  output logic             o_monitor_active,
  output logic             o_wdt_suspend,
  output logic             o_irq_block,
  output logic             o_core_stall
);

  localparam logic [2:0] PIN_GUARD = 3'(`DBU_PIN_GUARD_CYC);
  localparam logic [2:0] PIN_LOAD  = 3'(`DBU_STALL_CYC + `DBU_PIN_GUARD_CYC);

  // Inclusive range test; eight-bit users pass zero-extended operands
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  dbu_pkg::dbu_state_e state_q;
  dbu_pkg::dbu_state_e state_d;
  dbu_pkg::dbu_byte_t  bp_q [8];
  dbu_pkg::dbu_byte_t  mon_ctrl_two_q;
  dbu_pkg::dbu_byte_t  mon_ctrl_q;
  dbu_pkg::dbu_byte_t  brk_ctrl_q;
  dbu_pkg::dbu_byte_t  int_ctrl_q;
  dbu_pkg::dbu_byte_t  mon_data_q;
  dbu_pkg::dbu_byte_t  rdata_q;
  dbu_pkg::dbu_addr_t  bp_val [4];
  logic [3:0]          target_select_q;
  logic [5:0]          cause_q;
  logic [2:0]          sync1_q;
  logic [2:0]          sync2_q;
  logic                tclk_prev_q;
  logic                pin_prev_q;
  logic                ext_pend_q;
  logic                step_q;
  logic                step_seen_q;
  logic                step_nmi_q;
  logic [2:0]          pin_cnt_q;
  logic [2:0]          pin_cnt_d;
  logic                brk_before_q;
  logic                brk_after_q;
  logic                mon_start_q;
  logic                mon_active_q;
  logic                stall_q;
  logic                pin_oe_n_q;

  // Register decode
  wire sel_wr     = i_sfr_wr && (i_sfr_addr == `DBU_OFS_BP_SELECT);
  wire win_wr     = i_sfr_wr && (i_sfr_addr == `DBU_OFS_BP_WINDOW);
  wire sel_valid  = target_select_q[`DBU_SEL_VALID_BIT];
  wire [2:0] sel_idx = target_select_q[2:0];
  wire guard_set  = i_sfr_wdata[`DBU_SEL_GUARD_BIT];
  wire [3:0] cmp_en = mon_ctrl_q[`DBU_MC_EN_MSB:0];
  wire pair_range = brk_ctrl_q[`DBU_BC_PAIR_RANGE];
  wire cmp2_range = brk_ctrl_q[`DBU_BC_CMP2_RANGE];
  wire cmp3_range = brk_ctrl_q[`DBU_BC_CMP3_RANGE];
  wire pin_brk_en = brk_ctrl_q[`DBU_BC_PIN_BREAK_EN];
  wire pin_act_en = brk_ctrl_q[`DBU_BC_PIN_ACT_EN];
  wire pin_only   = brk_ctrl_q[`DBU_BC_PIN_ONLY];
  wire [3:0] eq_mode = {~cmp3_range, ~cmp2_range, ~pair_range, ~pair_range};

  // Each comparator is its low and high byte side by side
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cmp
      assign bp_val[g] = {bp_q[2*g+1], bp_q[2*g]};
    end
  endgenerate

  // Fetch breaks: only opcode-first fetches are offered, so later
  // instruction bytes never match
  wire [3:0] ip_eq;
  generate
    for (g = 0; g < 4; g++) begin : g_eq
      assign ip_eq[g] = i_fetch_first && cmp_en[g] && eq_mode[g]
                        && (i_fetch_addr == bp_val[g]);
    end
  endgenerate
  wire ip_rng   = i_fetch_first && cmp_en[0] && pair_range
                  && in_range(i_fetch_addr, bp_val[0], bp_val[1]);
  wire trap_hit = i_fetch_first && i_fetch_trap && i_trap_enable;
  wire hw_ip    = (|ip_eq) || ip_rng;

  // Data breaks: read range on comparator two, write range on three
  wire rd_hit = i_internal_data_memory_is_ram && i_internal_data_memory_rd && cmp_en[2] && cmp2_range
                && in_range({8'h00, i_internal_data_memory_rd_addr}, {8'h00, bp_q[4]},
                            {8'h00, bp_q[5]});
  wire wr_hit = i_internal_data_memory_is_ram && i_internal_data_memory_wr && cmp_en[3] && cmp3_range
                && in_range({8'h00, i_internal_data_memory_wr_addr}, {8'h00, bp_q[6]},
                            {8'h00, bp_q[7]});
  wire data_hit = rd_hit || wr_hit;

  // Synchronised asynchronous inputs
  wire tclk_s   = sync2_q[0];
  wire treq_s   = sync2_q[1];
  wire pin_s    = sync2_q[2];
  wire tport_ev = tclk_s && !tclk_prev_q && treq_s;
  // Own drive plus a guard is masked so the unit cannot break itself
  wire pin_ev   = pin_brk_en && pin_prev_q && !pin_s
                  && (pin_cnt_q == 3'h0);
  wire ext_req  = tport_ev || pin_ev;

  // Single step: inside NMI the first fetch after return breaks
  wire step_brk = step_q && i_fetch_first && !i_nmi_active
                  && (step_seen_q || step_nmi_q);

  wire running  = (state_q == dbu_pkg::DBU_ST_RUN);
  wire ext_take = running && ext_pend_q && !i_nmi_active;
  wire sync_ev  = hw_ip || trap_hit || step_brk;
  wire any_ev   = running && (sync_ev || data_hit || ext_take);

  // Read selection
  wire [7:0] win_data = sel_valid ? bp_q[sel_idx] : 8'h00;
  wire [7:0] status   = {2'h0, cause_q[`DBU_ST_DATA], ext_pend_q,
                         mon_active_q, cause_q[`DBU_ST_EXT:`DBU_ST_HW]};
  wire [7:0] rd_mux   =
    (i_sfr_addr == `DBU_OFS_MON_CTRL_TWO) ? mon_ctrl_two_q :
    (i_sfr_addr == `DBU_OFS_MON_CTRL)     ? mon_ctrl_q :
    (i_sfr_addr == `DBU_OFS_MON_STATUS)   ? status :
    (i_sfr_addr == `DBU_OFS_BRK_CTRL)     ? brk_ctrl_q :
    (i_sfr_addr == `DBU_OFS_INT_CTRL)     ? int_ctrl_q :
    (i_sfr_addr == `DBU_OFS_MON_DATA)     ? mon_data_q :
    (i_sfr_addr == `DBU_OFS_BP_SELECT)    ? {4'h0, target_select_q} :
    (i_sfr_addr == `DBU_OFS_BP_WINDOW)    ? win_data : 8'h00;

  // Action sequencing; events in stall or monitor are not re-entered
  always_comb begin
    state_d   = state_q;
    pin_cnt_d = (pin_cnt_q != 3'h0) ? pin_cnt_q - 3'h1 : 3'h0;
    unique case (state_q)
      dbu_pkg::DBU_ST_RUN: begin
        if (any_ev) begin
          if (pin_only) begin
            state_d   = dbu_pkg::DBU_ST_STALL;
            pin_cnt_d = PIN_LOAD;
          end else begin
            state_d = dbu_pkg::DBU_ST_MON;
            if (pin_act_en) begin
              pin_cnt_d = PIN_LOAD;
            end
          end
        end
      end
      dbu_pkg::DBU_ST_STALL: begin
        if (pin_cnt_q == PIN_GUARD + 3'h1) begin
          state_d = dbu_pkg::DBU_ST_RUN;
        end
      end
      dbu_pkg::DBU_ST_MON: begin
        if (i_monitor_exit) begin
          state_d = dbu_pkg::DBU_ST_RUN;
        end
      end
    endcase
  end

  // Two-stage synchronisers and edge history
  always_ff @(posedge i_clk) begin
    sync1_q     <= {i_dbg_pin_in, i_tport_break, i_tport_clk};
    sync2_q     <= sync1_q;
    tclk_prev_q <= tclk_s;
    pin_prev_q  <= pin_s;
  end

  // Select register: field moves only with its guard bit set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      target_select_q <= 4'h0;
    end else if (sel_wr && guard_set) begin
      target_select_q <= i_sfr_wdata[`DBU_SEL_FIELD_MSB:0];
    end
  end

  // Comparator bytes through the data window; reserved codes drop writes
  generate
    for (g = 0; g < 8; g++) begin : g_bp
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          bp_q[g] <= `DBU_RST_BYTE;
        end else if (win_wr && sel_valid && (sel_idx == 3'(g))) begin
          bp_q[g] <= i_sfr_wdata;
        end
      end
    end
  endgenerate

  // Directly addressed control bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mon_ctrl_two_q <= `DBU_RST_BYTE;
      mon_ctrl_q     <= `DBU_RST_BYTE;
      brk_ctrl_q     <= `DBU_RST_BYTE;
      int_ctrl_q     <= `DBU_RST_BYTE;
      mon_data_q     <= `DBU_RST_BYTE;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == `DBU_OFS_MON_CTRL_TWO) mon_ctrl_two_q <= i_sfr_wdata;
      if (i_sfr_addr == `DBU_OFS_MON_CTRL)     mon_ctrl_q     <= i_sfr_wdata;
      if (i_sfr_addr == `DBU_OFS_BRK_CTRL)     brk_ctrl_q     <= i_sfr_wdata;
      if (i_sfr_addr == `DBU_OFS_INT_CTRL)     int_ctrl_q     <= i_sfr_wdata;
      if (i_sfr_addr == `DBU_OFS_MON_DATA)     mon_data_q     <= i_sfr_wdata;
    end
  end

  // Read data is registered; it stands until the next read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= `DBU_RST_BYTE;
    end else if (i_sfr_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // External break pending; a new request wins over the take
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_pend_q <= 1'b0;
    end else begin
      ext_pend_q <= ext_req || (ext_pend_q && !ext_take);
    end
  end

  // Step tracking after a monitor exit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      step_q      <= 1'b0;
      step_seen_q <= 1'b0;
      step_nmi_q  <= 1'b0;
    end else if (i_monitor_exit && !running) begin
      step_q      <= i_step_req;
      step_seen_q <= 1'b0;
      step_nmi_q  <= i_nmi_active;
    end else if (any_ev) begin
      step_q      <= 1'b0;
    end else if (step_q && i_fetch_first && !i_nmi_active) begin
      step_seen_q <= 1'b1;
    end
  end

  // Cause of the last break, replaced by each new one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cause_q <= 6'h00;
    end else if (any_ev) begin
      cause_q <= {data_hit, 2'h0, ext_take, trap_hit, hw_ip || step_brk};
    end
  end

  // State and registered action outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q      <= dbu_pkg::DBU_ST_RUN;
      pin_cnt_q    <= 3'h0;
      brk_before_q <= 1'b0;
      brk_after_q  <= 1'b0;
      mon_start_q  <= 1'b0;
      mon_active_q <= 1'b0;
      stall_q      <= 1'b0;
      pin_oe_n_q   <= 1'b1;
    end else begin
      state_q      <= state_d;
      pin_cnt_q    <= pin_cnt_d;
      brk_before_q <= any_ev && (sync_ev || ext_take);
      brk_after_q  <= any_ev && data_hit;
      mon_start_q  <= any_ev && !pin_only;
      mon_active_q <= (state_d == dbu_pkg::DBU_ST_MON);
      stall_q      <= (state_d == dbu_pkg::DBU_ST_STALL);
      pin_oe_n_q   <= !(pin_cnt_d > PIN_GUARD);
    end
  end

  assign o_sfr_rdata      = rdata_q;
  assign o_dbg_pin_out    = 1'b0;
  assign o_dbg_pin_oe_n   = pin_oe_n_q;
  assign o_break_before   = brk_before_q;
  assign o_break_after    = brk_after_q;
  assign o_monitor_start  = mon_start_q;
  assign o_monitor_active = mon_active_q;
  assign o_wdt_suspend    = mon_active_q;
  assign o_irq_block      = mon_active_q;
  assign o_core_stall     = stall_q;

  // Checks on the select guard, data window, action timing and break logic
  AST_SEL_GUARD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (sel_wr && !guard_set) |=> $stable(target_select_q))
    else $error("select changed without guard bit");

  AST_SEL_LOAD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (sel_wr && guard_set) |=> (target_select_q == $past(i_sfr_wdata[3:0])))
    else $error("guarded select write not taken");

  AST_RSVD_ZERO: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_sfr_rd && i_sfr_addr == `DBU_OFS_BP_SELECT) |=> (o_sfr_rdata[7:5] == 3'h0))
    else $error("reserved select bits read nonzero");

  AST_WINDOW_RD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_sfr_rd && i_sfr_addr == `DBU_OFS_BP_WINDOW && sel_valid)
    |=> (o_sfr_rdata == bp_q[$past(sel_idx)]))
    else $error("window read returned wrong byte");

  AST_STALL_LEN: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_core_stall) |-> o_core_stall[*4] ##1 !o_core_stall)
    else $error("core stall not four cycles");

  AST_PIN_LOW: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $fell(o_dbg_pin_oe_n) |-> !o_dbg_pin_oe_n[*4] ##1 o_dbg_pin_oe_n)
    else $error("debug pin low time not four cycles");

  AST_WDT_HOLD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_monitor_start |-> (o_wdt_suspend && o_irq_block) until i_monitor_exit)
    else $error("watchdog not suspended in monitor");

  AST_EXT_HELD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (ext_pend_q && i_nmi_active) |=> (ext_pend_q && !$rose(cause_q[`DBU_ST_EXT])))
    else $error("external break taken during NMI");

  AST_TRAP: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (running && i_fetch_first && i_fetch_trap && i_trap_enable) |=> o_break_before)
    else $error("enabled trap did not break");

  AST_DATA_AFTER: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (running && data_hit && !sync_ev && !ext_take) |=> (o_break_after && !o_break_before [*1]))
    else $error("data break not signalled after access");

  AST_IP_RANGE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (running && i_fetch_first && cmp_en[0] && pair_range
     && i_fetch_addr >= bp_val[0] && i_fetch_addr <= bp_val[1]) |=> o_break_before)
    else $error("fetch range break missed");

endmodule

// File: verification/dbu_far_end.sv
/*
  Far end of the debug breakpoint unit: the serial debugger's test
  port and an outside agent on the open-drain debug control pin.
  Assumes the unit drives the pin low only while its enable is low.
*/
`timescale 1ns/10ps

module dbu_far_end (
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  output logic      o_tport_clk,
  output logic      o_tport_break,
  output logic      o_pin_level
);
  logic ext_low;

  // Idle levels: test port clock stands low outside frames
  initial begin
    o_tport_clk = 1'b0;
    o_tport_break = 1'b0;
    ext_low = 1'b0;
  end

  // Pull-up wire: low whenever any party pulls it
  assign o_pin_level = ((!i_pin_oe_n && !i_pin_out) || ext_low) ? 1'b0 : 1'b1;

  // Break request frame, four link clocks of 80 ns; request only on the first
  task automatic send_break();
    o_tport_break = 1'b1;
    repeat (4) begin
      #40 o_tport_clk = 1'b1;
      #40 o_tport_clk = 1'b0;
      o_tport_break = 1'b0;
    end
  endtask

  // Outside agent pulls the pin low for a while
  task automatic pin_low(input int ns);
    ext_low = 1'b1;
    #(ns) ext_low = 1'b0;
  endtask
endmodule

// File: verification/dbu_top_test.sv
/*
  Testbench of the debug breakpoint unit: register window, comparator
  modes, trap, external breaks and pin actions.
  Assumes dbu_far_end for the test port and the debug pin.
*/
`timescale 1ns/10ps
`include "dbu_cfg.svh"

module dbu_top_test;
  logic        i_clk, i_rst, i_sfr_wr, i_sfr_rd, i_fetch_first, i_fetch_trap;
  logic        i_trap_enable, i_internal_data_memory_rd, i_internal_data_memory_wr, i_nmi_active, i_monitor_exit, i_step_req;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, i_internal_data_memory_addr, o_sfr_rdata;
  logic [15:0] i_fetch_addr, n_stall, n_oe, n_start;
  logic        tclk, tbrk, pin, o_dbg_pin_out, o_dbg_pin_oe_n, o_break_before;
  logic        o_break_after, o_monitor_start, o_monitor_active, o_wdt_suspend;
  logic        o_irq_block, o_core_stall, seen_b, seen_a, mon;
  int          n_mismatch, total_checks, cyc;
  logic [7:0]  bv [8] = '{8'h08, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20, 8'h40, 8'h44};

  dbu_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_fetch_first(i_fetch_first),
    .i_fetch_addr(i_fetch_addr), .i_fetch_trap(i_fetch_trap),
    .i_trap_enable(i_trap_enable), .i_internal_data_memory_is_ram(1'b1), .i_internal_data_memory_rd(i_internal_data_memory_rd),
    .i_internal_data_memory_rd_addr(i_internal_data_memory_addr), .i_internal_data_memory_wr(i_internal_data_memory_wr),
    .i_internal_data_memory_wr_addr(i_internal_data_memory_addr), .i_nmi_active(i_nmi_active),
    .i_monitor_exit(i_monitor_exit), .i_step_req(i_step_req), .i_tport_clk(tclk),
    .i_tport_break(tbrk), .i_dbg_pin_in(pin), .o_dbg_pin_out(o_dbg_pin_out),
    .o_dbg_pin_oe_n(o_dbg_pin_oe_n), .o_break_before(o_break_before),
    .o_break_after(o_break_after), .o_monitor_start(o_monitor_start),
    .o_monitor_active(o_monitor_active), .o_wdt_suspend(o_wdt_suspend),
    .o_irq_block(o_irq_block), .o_core_stall(o_core_stall));

  dbu_far_end i_far (.i_pin_out(o_dbg_pin_out), .i_pin_oe_n(o_dbg_pin_oe_n),
    .o_tport_clk(tclk), .o_tport_break(tbrk), .o_pin_level(pin));

  // 100 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-cycle strobes; register read data is valid after the read edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clk);
    i_sfr_rd <= 1'b0;
    @(posedge i_clk);
    cmp({8'h00, o_sfr_rdata}, {8'h00, exp});
  endtask

  // Mode setup: comparator enables, then break control
  task automatic cfg(input logic [7:0] en, input logic [7:0] bc);
    wr(`DBU_OFS_MON_CTRL, en);
    wr(`DBU_OFS_BRK_CTRL, bc);
  endtask

  task automatic fetch(input logic first, input logic [15:0] a, input logic trap);
    @(posedge i_clk);
    i_fetch_first <= first;
    i_fetch_addr <= a;
    i_fetch_trap <= trap;
    @(posedge i_clk);
    i_fetch_first <= 1'b0;
    i_fetch_trap <= 1'b0;
  endtask

  task automatic mem(input logic r, input logic w, input logic [7:0] a);
    @(posedge i_clk);
    i_internal_data_memory_rd <= r;
    i_internal_data_memory_wr <= w;
    i_internal_data_memory_addr <= a;
    @(posedge i_clk);
    i_internal_data_memory_rd <= 1'b0;
    i_internal_data_memory_wr <= 1'b0;
  endtask

  // Collect action outputs for n cycles, then leave the monitor if entered
  task automatic watch(input int n);
    seen_b = 1'b0;
    seen_a = 1'b0;
    mon = 1'b0;
    n_stall = '0;
    n_oe = '0;
    n_start = '0;
    repeat (n) begin
      @(posedge i_clk);
      seen_b = seen_b | o_break_before;
      seen_a = seen_a | o_break_after;
      mon = mon | (o_monitor_active & o_wdt_suspend & o_irq_block);
      n_stall = n_stall + 16'(o_core_stall);
      n_oe = n_oe + 16'(!o_dbg_pin_oe_n);
      n_start = n_start + 16'(o_monitor_start);
    end
    if (o_monitor_active === 1'b1) begin
      i_monitor_exit <= 1'b1;
      @(posedge i_clk);
      i_monitor_exit <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask

  initial begin
    {i_rst, i_sfr_wr, i_sfr_rd, i_fetch_first, i_fetch_trap, i_trap_enable} = 6'h20;
    {i_internal_data_memory_rd, i_internal_data_memory_wr, i_nmi_active, i_monitor_exit, i_step_req} = 5'h00;
    {i_sfr_addr, i_sfr_wdata, i_internal_data_memory_addr, i_fetch_addr} = 40'h0;
    {n_mismatch, total_checks, cyc} = '0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`DBU_OFS_BP_SELECT, 8'h00);
    rd(`DBU_OFS_BP_WINDOW, 8'h00);
    wr(`DBU_OFS_BP_SELECT, 8'h0c);
    rd(`DBU_OFS_BP_SELECT, 8'h00);
    wr(`DBU_OFS_BP_SELECT, 8'h18);
    rd(`DBU_OFS_BP_SELECT, 8'h08);
    // Fill all eight bytes, then read each one back through the window
    for (int c = 0; c < 8; c++) begin
      wr(`DBU_OFS_BP_SELECT, 8'(8'h18 + c));
      wr(`DBU_OFS_BP_WINDOW, bv[c]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(`DBU_OFS_BP_SELECT, 8'(8'h18 + c));
      rd(`DBU_OFS_BP_WINDOW, bv[c]);
    end
    wr(`DBU_OFS_BP_SELECT, 8'h13);
    wr(`DBU_OFS_BP_WINDOW, 8'h5a);
    rd(`DBU_OFS_BP_WINDOW, 8'h00);
    wr(`DBU_OFS_BP_SELECT, 8'h18);
    rd(`DBU_OFS_BP_WINDOW, 8'h08);
    rd(8'h80, 8'h00);
    // Result word is {before, after, monitor}: 5 fetch break, 3 data break
    cfg(8'h01, 8'h00);
    fetch(1'b1, 16'h1008, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    fetch(1'b0, 16'h1008, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    fetch(1'b1, 16'h1009, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    cfg(8'h02, 8'h00);
    fetch(1'b1, 16'h1010, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    // Range pair zero to one, bounds inclusive
    cfg(8'h03, 8'h01);
    for (int k = 0; k < 5; k++) begin
      fetch(1'b1, 16'h1007 + 16'(k * 3), 1'b0);
      watch(6);
      cmp({seen_b, seen_a, mon}, (k == 0 || k == 4) ? 16'h0 : 16'h5);
    end
    // Comparator two, read range with equal bounds, writes ignored
    cfg(8'h04, 8'h02);
    mem(1'b1, 1'b0, 8'h20);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h3);
    mem(1'b1, 1'b0, 8'h21);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    mem(1'b0, 1'b1, 8'h20);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    cfg(8'h04, 8'h00);
    fetch(1'b1, 16'h2020, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    // Comparator three, write range 0x40 to 0x44
    cfg(8'h08, 8'h04);
    mem(1'b0, 1'b1, 8'h44);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h3);
    mem(1'b0, 1'b1, 8'h45);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    mem(1'b1, 1'b0, 8'h42);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    // Trap only while enabled
    cfg(8'h00, 8'h00);
    fetch(1'b1, 16'h0123, 1'b1);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    i_trap_enable <= 1'b1;
    fetch(1'b1, 16'h0123, 1'b1);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    // Break inside NMI service; a step then runs on until after the return
    cfg(8'h01, 8'h00);
    i_nmi_active <= 1'b1;
    i_step_req <= 1'b1;
    fetch(1'b1, 16'h1008, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    i_step_req <= 1'b0;
    fetch(1'b1, 16'h0200, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h0);
    i_nmi_active <= 1'b0;
    fetch(1'b1, 16'h0202, 1'b0);
    watch(6);
    cmp({seen_b, seen_a, mon}, 16'h5);
    // Pin actions: alone with a four-cycle stall, then beside the monitor
    for (int k = 0; k < 2; k++) begin
      cfg(8'h01, k == 0 ? 8'h20 : 8'h10);
      fetch(1'b1, 16'h1008, 1'b0);
      watch(10);
      cmp(n_stall, k == 0 ? 16'h4 : 16'h0);
      cmp(n_oe, 16'h4);
      cmp({15'h0, mon}, k == 0 ? 16'h0 : 16'h1);
      cmp(n_start, k == 0 ? 16'h0 : 16'h1);
    end
    // External pin break, then one held off by NMI service
    cfg(8'h00, 8'h08);
    fork
      i_far.pin_low(60);
      watch(12);
    join
    cmp({seen_b, seen_a, mon}, 16'h5);
    i_nmi_active <= 1'b1;
    fork
      i_far.pin_low(60);
      watch(12);
    join
    cmp({seen_b, seen_a, mon}, 16'h0);
    i_nmi_active <= 1'b0;
    watch(12);
    cmp({seen_b, seen_a, mon}, 16'h5);
    // Test port break request
    cfg(8'h00, 8'h00);
    fork
      i_far.send_break();
      watch(50);
    join
    cmp({seen_b, seen_a, mon}, 16'h5);
    // One request frame gives exactly one break
    watch(20);
    cmp({seen_b, seen_a, mon}, 16'h0);
    end_sim();
  end
endmodule
